// >>> shared/rlc_pkg.sv
// Constants and types for the reset level cascade
package rlc_pkg;
  // Sequencing clock rate and pin hold limit
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PIN_LONG_S = 1;
  localparam int unsigned PIN_LONG_CYCLES = PIN_LONG_S * CLK_HZ;
  // Least cycles each level is held before the next one releases
  localparam int unsigned HOLD_NS = 4;
  localparam logic [3:0] HOLD_CYCLES = 4'(((HOLD_NS * 250) + 999) / 1000);
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0] {
    RLC_RUN = 3'h4,
    RLC_POR = 3'h1,
    RLC_BOR = 3'h3,
    RLC_BOOT = 3'h2,
    RLC_SYS = 3'h6,
    RLC_CPU = 3'h5
  } rlc_state_e;
endpackage : rlc_pkg

// >>> logic/rlc_reset_level_cascade.sv
// Reset level cascade sequencer
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Ordered levels; any level asserts all lower
// - Power-on from threshold, software, long pin
// - Power-on clears retention, re-enables pin, debug
// - Brownout from thresholds or shutdown exit
// - Brownout resets power unit, core domain
// - Boot from brownout, software, clock fail, short pin
// - Boot runs config, resets core, clocks, pins
// - Boot power-cycles static RAM
// - System from boot, bootloader, watchdog, software, debug
// - System spares real-time clock and oscillator loop
// - System release enters run state
// - Processor-only reset leaves peripherals alone
// - Processor-only raised by software or debug only
module rlc_reset_level_cascade #(
  parameter int unsigned PIN_LONG_CYC = rlc_pkg::PIN_LONG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic porThreshold,
  input wire logic borThreshold,
  input wire logic shutdownExit,
  input wire logic extResetPin_n,
  input wire logic swPorReq,
  input wire logic swBootReq,
  input wire logic clockFail,
  input wire logic bootloaderEvent,
  input wire logic watchdogExpire,
  input wire logic swSysReq,
  input wire logic debugSysReq,
  input wire logic swCpuReq,
  input wire logic debugCpuReq,
  output logic porLevel,
  output logic brownoutLevel,
  output logic bootResetLevel,
  output logic systemResetLevel,
  output logic processorOnlyReset,
  output logic retainedMemClear,
  output logic pinFuncEnable,
  output logic debugPortEnable,
  output logic bootConfigRun,
  output logic sramPowerOff,
  output logic runState
);
  localparam int NSRC = 14;

  typedef struct packed {
    logic [NSRC-1:0] syncA;
    logic [NSRC-1:0] syncB;
    rlc_pkg::rlc_state_e state;
    logic [3:0] hold;
    logic [rlc_pkg::CNT_W-1:0] pinCnt;
    logic pinLow;
    logic longSeen;
    logic porReq;
    logic bootReq;
    logic sysReq;
    logic cpuReq;
    logic [10:0] outs;
  } rlc_reg_s;

  rlc_reg_s stReg;
  rlc_reg_s stNext;
  logic [NSRC-1:0] rawIn;
  logic [NSRC-1:0] sIn;

  assign rawIn = {debugCpuReq, swCpuReq, debugSysReq, swSysReq,
                  watchdogExpire, bootloaderEvent, clockFail, swBootReq,
                  swPorReq, ~extResetPin_n, shutdownExit, borThreshold,
                  porThreshold, 1'b0};
  assign sIn = stReg.syncB;

  always_comb begin
    logic pinRelease;
    logic pinLongNow;
    logic [10:0] o;
    pinRelease = 1'b0;
    pinLongNow = 1'b0;
    o = '0;
    stNext = stReg;
    // Two flops on every asynchronous request
    stNext.syncA = rawIn;
    stNext.syncB = stReg.syncA;
    stNext.pinLow = sIn[4];
    pinRelease = stReg.pinLow & ~sIn[4];
    // Saturating low-time counter decides long or short press
    if (sIn[4]) begin
      if (stReg.pinCnt < rlc_pkg::CNT_W'(PIN_LONG_CYC)) begin
        stNext.pinCnt = stReg.pinCnt + 1'b1;
      end
    end else begin
      stNext.pinCnt = '0;
    end
    pinLongNow = sIn[4] && !stReg.longSeen &&
                 (stReg.pinCnt >= rlc_pkg::CNT_W'(PIN_LONG_CYC));
    if (pinLongNow) begin
      stNext.longSeen = 1'b1;
    end else if (!sIn[4]) begin
      stNext.longSeen = 1'b0;
    end
    // Requests latch so a busy cascade does not lose them
    stNext.porReq = stReg.porReq | sIn[1] | sIn[5] | pinLongNow;
    stNext.bootReq = stReg.bootReq | sIn[6] | sIn[7] |
                     (pinRelease & ~stReg.longSeen);
    stNext.sysReq = stReg.sysReq | (|sIn[11:8]);
    stNext.cpuReq = stReg.cpuReq | sIn[13] | sIn[12];
    if (stReg.hold != 4'h0) begin
      stNext.hold = stReg.hold - 4'h1;
    end
    // Higher source wins: jump into the cascade at the highest level
    if (stNext.porReq) begin
      stNext.state = rlc_pkg::RLC_POR;
      stNext.porReq = 1'b0;
      stNext.hold = rlc_pkg::HOLD_CYCLES;
    end else if (sIn[2] | sIn[3]) begin
      // Brownout on the brownout threshold or shutdown exit
      if (stReg.state != rlc_pkg::RLC_POR) begin
        stNext.state = rlc_pkg::RLC_BOR;
        stNext.hold = rlc_pkg::HOLD_CYCLES;
      end
    end else if (stReg.hold == 4'h0) begin
      case (stReg.state)
        rlc_pkg::RLC_POR: begin
          stNext.state = rlc_pkg::RLC_BOR;
          stNext.hold = rlc_pkg::HOLD_CYCLES;
        end
        rlc_pkg::RLC_BOR: begin
          stNext.state = rlc_pkg::RLC_BOOT;
          stNext.hold = rlc_pkg::HOLD_CYCLES;
        end
        rlc_pkg::RLC_BOOT: begin
          stNext.state = rlc_pkg::RLC_SYS;
          stNext.hold = rlc_pkg::HOLD_CYCLES;
        end
        rlc_pkg::RLC_SYS: begin
          stNext.state = rlc_pkg::RLC_RUN;
          stNext.cpuReq = 1'b0;
        end
        rlc_pkg::RLC_CPU: begin
          stNext.state = rlc_pkg::RLC_RUN;
        end
        rlc_pkg::RLC_RUN: begin
          if (stReg.bootReq) begin
            stNext.state = rlc_pkg::RLC_BOOT;
            stNext.bootReq = 1'b0;
            stNext.hold = rlc_pkg::HOLD_CYCLES;
          end else if (stReg.sysReq) begin
            stNext.state = rlc_pkg::RLC_SYS;
            stNext.sysReq = 1'b0;
            stNext.hold = rlc_pkg::HOLD_CYCLES;
          end else if (stReg.cpuReq) begin
            stNext.state = rlc_pkg::RLC_CPU;
            stNext.cpuReq = 1'b0;
            stNext.hold = rlc_pkg::HOLD_CYCLES;
          end
        end
        default: begin
          stNext.state = rlc_pkg::RLC_POR;
        end
      endcase
    end
    // Cascade entered covers any pending lower request
    if (stNext.state inside {rlc_pkg::RLC_POR, rlc_pkg::RLC_BOR,
                             rlc_pkg::RLC_BOOT}) begin
      stNext.bootReq = 1'b0;
      stNext.sysReq = 1'b0;
    end
    // Each level implies every lower one
    o[0] = stNext.state == rlc_pkg::RLC_POR;
    o[1] = o[0] | (stNext.state == rlc_pkg::RLC_BOR);
    o[2] = o[1] | (stNext.state == rlc_pkg::RLC_BOOT);
    o[3] = o[2] | (stNext.state == rlc_pkg::RLC_SYS);
    o[4] = o[3] | (stNext.state == rlc_pkg::RLC_CPU);
    o[5] = o[0];
    o[6] = stReg.outs[6] | o[0];
    o[7] = stReg.outs[7] | o[0];
    o[8] = stNext.state == rlc_pkg::RLC_BOOT;
    o[9] = o[2];
    o[10] = stNext.state == rlc_pkg::RLC_RUN;
    stNext.outs = o;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stReg <= '{state: rlc_pkg::RLC_POR, hold: 4'h1,
                 outs: 11'h2FF, default: '0};
    end else begin
      stReg <= stNext;
    end
  end

  assign porLevel = stReg.outs[0];
  assign brownoutLevel = stReg.outs[1];
  assign bootResetLevel = stReg.outs[2];
  assign systemResetLevel = stReg.outs[3];
  assign processorOnlyReset = stReg.outs[4];
  assign retainedMemClear = stReg.outs[5];
  assign pinFuncEnable = stReg.outs[6];
  assign debugPortEnable = stReg.outs[7];
  assign bootConfigRun = stReg.outs[8];
  assign sramPowerOff = stReg.outs[9];
  assign runState = stReg.outs[10];

  // All checks run on the sequencing clock and sleep through reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_porThenBor;
    porLevel ##1 (porLevel [*1]) ##[1:3] (brownoutLevel && !porLevel);
  endsequence

  // A boot entry is never shorter than two cycles
  sequence s_bootHeld;
    bootConfigRun ##1 bootResetLevel;
  endsequence

  a_level_nesting: assert property (
    (processorOnlyReset || !systemResetLevel) &&
    (systemResetLevel || !bootResetLevel) &&
    (bootResetLevel || !brownoutLevel) &&
    (brownoutLevel || !porLevel))
    else $error("lower reset level not asserted");
  a_por_cascades: assert property (
    $fell(porLevel) |-> brownoutLevel)
    else $error("power-on did not hand to brownout");
  a_por_clears_mem: assert property (
    porLevel |-> retainedMemClear && pinFuncEnable && debugPortEnable)
    else $error("power-on side effects missing");
  a_mem_clear_por: assert property (
    retainedMemClear == porLevel)
    else $error("retained memory clear outside power-on");
  a_bor_cascades: assert property (
    $fell(brownoutLevel) |-> bootResetLevel && bootConfigRun)
    else $error("brownout did not hand to boot");
  a_sram_cycled: assert property (
    bootConfigRun |-> sramPowerOff)
    else $error("sram not power cycled in boot");
  a_sram_follows: assert property (
    sramPowerOff == bootResetLevel)
    else $error("sram power does not follow boot level");
  a_boot_run_only: assert property (
    bootConfigRun |-> bootResetLevel && !brownoutLevel)
    else $error("boot routine outside boot level");
  a_boot_cascades: assert property (
    $fell(bootResetLevel) |-> systemResetLevel)
    else $error("boot did not hand to system");
  a_run_on_release: assert property (
    $fell(systemResetLevel) |-> runState)
    else $error("run state not entered");
  a_run_excl: assert property (
    runState == !processorOnlyReset)
    else $error("run state while a reset level stands");

  // Request latency is sync, latch, then state; waits cover a busy level
  a_sw_por_raise: assert property (
    (swPorReq && !porLevel) |-> ##[1:4] porLevel)
    else $error("software power-on not raised");
  a_por_threshold: assert property (
    $rose(porThreshold) |-> ##[1:4] porLevel)
    else $error("threshold power-on not raised");
  a_long_press_por: assert property (
    $rose(stReg.longSeen) |-> porLevel)
    else $error("long pin press did not raise power-on");
  a_brownout_raise: assert property (
    $rose(borThreshold) |-> ##[1:4] brownoutLevel)
    else $error("brownout not raised");
  a_shutdown_bor: assert property (
    $rose(shutdownExit) |-> ##[1:4] brownoutLevel)
    else $error("shutdown exit did not raise brownout");
  a_boot_sources: assert property (
    (swBootReq || clockFail) && !bootResetLevel |->
    ##[1:12] bootResetLevel)
    else $error("boot request not raised");
  a_sys_sources: assert property (
    (bootloaderEvent || watchdogExpire || swSysReq || debugSysReq) &&
    !systemResetLevel |-> ##[1:12] systemResetLevel)
    else $error("system request not raised");
  a_cpu_sources: assert property (
    (swCpuReq || debugCpuReq) && !processorOnlyReset |->
    ##[1:12] processorOnlyReset)
    else $error("processor-only request not raised");
  a_cpu_from_req: assert property (
    $rose(processorOnlyReset) && !systemResetLevel |-> $past(stReg.cpuReq))
    else $error("processor-only reset without its request");
  a_cpu_spares_sys: assert property (
    processorOnlyReset && !systemResetLevel |=>
    !systemResetLevel || brownoutLevel)
    else $error("processor-only reset spread to peripherals");

  // Minimum hold keeps a level from vanishing before logic sees it
  a_level_held: assert property (
    $rose(porLevel) |-> s_porThenBor)
    else $error("power-on level not held");
  a_boot_held: assert property (
    $rose(bootConfigRun) |-> s_bootHeld)
    else $error("boot level not held");
  a_sys_held: assert property (
    $rose(systemResetLevel) |=> systemResetLevel)
    else $error("system level not held");
  a_cpu_held: assert property (
    $rose(processorOnlyReset) |=> processorOnlyReset)
    else $error("processor-only level not held");
endmodule : rlc_reset_level_cascade

`default_nettype wire

// >>> tb/rlc_far_side.sv
// Far-side model: supply monitors, reset pin, watchdog, software, debugger
`timescale 1ns/1ps
`default_nettype none

module rlc_far_side (
  input wire logic [12:0] cmd,
  output logic [11:0] reqs,
  output logic pinLevel_n
);
  // Request lines follow the bench command one for one
  assign reqs = cmd[11:0];
  // Pin has a pull-up, so it idles high between presses
  assign pinLevel_n = ~cmd[12];
endmodule : rlc_far_side

`default_nettype wire

// >>> tb/rlc_reset_level_cascade_test.sv
// Self-checking bench for the reset level cascade
`timescale 1ns/1ps
`default_nettype none

module rlc_reset_level_cascade_test;
  // Short pin limit keeps the long-press case brief
  localparam int PIN_CYC = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] cmd = 13'h0000;
  logic [11:0] rq;
  logic pin_n, porLevel, brownoutLevel, bootResetLevel, systemResetLevel;
  logic processorOnlyReset, retainedMemClear, pinFuncEnable;
  logic debugPortEnable, bootConfigRun, sramPowerOff, runState;
  int mismatches = 0;
  int n_checks = 0;

  always #2 sys_clk = ~sys_clk;

  rlc_far_side i_far (.cmd(cmd), .reqs(rq), .pinLevel_n(pin_n));

  rlc_reset_level_cascade #(.PIN_LONG_CYC(PIN_CYC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .porThreshold(rq[10]),
    .borThreshold(rq[8]), .shutdownExit(rq[9]), .extResetPin_n(pin_n),
    .swPorReq(rq[11]), .swBootReq(rq[6]), .clockFail(rq[7]),
    .bootloaderEvent(rq[2]), .watchdogExpire(rq[3]), .swSysReq(rq[4]),
    .debugSysReq(rq[5]), .swCpuReq(rq[0]), .debugCpuReq(rq[1]),
    .porLevel(porLevel), .brownoutLevel(brownoutLevel),
    .bootResetLevel(bootResetLevel), .systemResetLevel(systemResetLevel),
    .processorOnlyReset(processorOnlyReset),
    .retainedMemClear(retainedMemClear), .pinFuncEnable(pinFuncEnable),
    .debugPortEnable(debugPortEnable), .bootConfigRun(bootConfigRun),
    .sramPowerOff(sramPowerOff), .runState(runState)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic check(string what, logic [4:0] exp, logic [4:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Drive one source for n cycles and judge the whole cascade it starts
  task automatic window(int bitIdx, int n, int lvl);
    logic [4:0] seen, lv, mask, sexp;
    logic [2:0] side;
    int run;
    seen = 5'h00;
    side = 3'h0;
    run = 0;
    for (int c = 0; c < 80; c++) begin
      @(negedge sys_clk);
      cmd = (c < n) ? 13'(1 << bitIdx) : 13'h0000;
      lv = {porLevel, brownoutLevel, bootResetLevel, systemResetLevel,
        processorOnlyReset};
      seen |= lv;
      side |= {retainedMemClear, bootConfigRun, sramPowerOff};
      check("nesting", 5'h00, lv & (lv + 5'h01));
      if (systemResetLevel === 1'b1) run++;
      else if (run != 0) begin
        check("hold", 5'h01, 5'(run >= 2));
        run = 0;
      end
    end
    // Nested mask: the raised level and every one below it
    mask = 5'((32'h1 << (lvl + 1)) - 1);
    sexp = {2'h0, lvl == 4, lvl >= 2, lvl >= 2};
    check("levels", mask, seen);
    check("side", sexp, {2'h0, side});
    check("run", 5'h01, {4'h0, runState});
  endtask : window

  task automatic after_reset();
    int w;
    w = 0;
    while (runState !== 1'b1 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    check("boot run", 5'h01, {4'h0, runState});
    check("enables", 5'h03, {3'h0, pinFuncEnable, debugPortEnable});
  endtask : after_reset

  // Every trigger source but the pin once, with the highest level it must raise
  task automatic sources();
    int lv;
    for (int i = 0; i < 12; i++) begin
      lv = (i < 2) ? 0 : (i < 6) ? 1 : (i < 8) ? 2 : (i < 10) ? 3 : 4;
      window(i, 1, lv);
    end
  endtask : sources

  task automatic pin_presses();
    window(12, PIN_CYC / 4, 2);
    window(12, PIN_CYC + 10, 4);
  endtask : pin_presses

  initial begin
    #(4 * 20000);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    after_reset();
    sources();
    pin_presses();
    test_done();
  end
endmodule : rlc_reset_level_cascade_test

`default_nettype wire
